/* File: cpf_pkg.sv */
// Package for the cell protection fault controller: states, timing, gate drive codes.
// Assumes a 50 MHz system clock; detection timers tick at a 10 kHz internal rate.
package cpf_pkg;
    // System clock and internal timer tick
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned TICK_HZ        = 10_000;
    localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_DIV_W     = 13;
    // Short-circuit delay, fixed, in microseconds
    localparam int unsigned SC_DELAY_US    = 250;
    localparam int unsigned SC_DELAY_TICKS = (SC_DELAY_US * TICK_HZ + 999_999) / 1_000_000;
    // Default detection delays in milliseconds (factory selectable)
    localparam int unsigned OVC_DELAY_MS   = 1000;
    localparam int unsigned UVD_DELAY_MS   = 96;
    localparam int unsigned OCD_DELAY_MS   = 16;
    localparam int unsigned OCC_DELAY_MS   = 8;
    localparam int unsigned REL_DELAY_MS   = 8;
    localparam int unsigned TMR_W          = 16;
    // Gate drive level codes for the charge gate
    localparam logic [1:0]  GATE_OFF       = 2'h0;
    localparam logic [1:0]  GATE_ON        = 2'h1;
    localparam logic [1:0]  GATE_CELL      = 2'h2;
    localparam logic [1:0]  GATE_PACKNEG   = 2'h3;

    // Protection states, one-hot
    typedef enum logic [6:0] {
        CPF_NORMAL   = 7'h01,
        CPF_OVC      = 7'h02,
        CPF_UVD      = 7'h04,
        CPF_PDOWN    = 7'h08,
        CPF_OCD      = 7'h10,
        CPF_OCC      = 7'h20,
        CPF_ZVCHG    = 7'h40
    } cpf_state_t;

    // Convert milliseconds to timer ticks
    function automatic int unsigned ms_ticks(input int unsigned ms);
        return (ms * TICK_HZ) / 1000;
    endfunction
endpackage

/* File: cpf_tmr_if.sv */
// Interface carrying one detection timer's request and result.
// Assumes the tick pulse and clock come from the controller.
interface cpf_tmr_if;
    logic run;
    logic tick;
    logic done;
    modport ctrl (output run, output tick, input done);
    modport tmr  (input run, input tick, output done);
endinterface

/* File: cpf_sync.sv */
// Two-flop synchroniser for one comparator level.
// Assumes asynchronous inputs from analog comparators.
module cpf_sync (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            q       <= 1'b0;
        end else if (ce) begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // cpf_sync

/* File: cpf_delay.sv */
// Qualifying delay timer: done after LIMIT uninterrupted ticks of run.
// Assumes tick is a one-cycle pulse on clk_sys.
module cpf_delay #(
    parameter int unsigned LIMIT = 1
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    cpf_tmr_if.tmr    t
);
    logic [cpf_pkg::TMR_W-1:0] cnt_ff;

    // Refuse limits the counter cannot reach
    if (LIMIT < 1 || LIMIT >= (1 << cpf_pkg::TMR_W)) begin : g_bad_limit
        $error("cpf_delay LIMIT out of range");
    end

    // Any drop of run restarts from zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (ce) begin
            if (!t.run)
                cnt_ff <= '0;
            else if (t.tick && cnt_ff < LIMIT[cpf_pkg::TMR_W-1:0])
                cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign t.done = t.run && (cnt_ff >= LIMIT[cpf_pkg::TMR_W-1:0]);
endmodule // cpf_delay

/* File: cpf_fsm.sv */
// Cell protection fault controller: comparators in, gate drives and switches out.
// Assumes comparator outputs are asynchronous levels from the analog front end.
module cpf_fsm #(
    parameter int unsigned OVC_TICKS = cpf_pkg::ms_ticks(cpf_pkg::OVC_DELAY_MS),
    parameter int unsigned UVD_TICKS = cpf_pkg::ms_ticks(cpf_pkg::UVD_DELAY_MS),
    parameter int unsigned OCD_TICKS = cpf_pkg::ms_ticks(cpf_pkg::OCD_DELAY_MS),
    parameter int unsigned OCC_TICKS = cpf_pkg::ms_ticks(cpf_pkg::OCC_DELAY_MS),
    parameter int unsigned REL_TICKS = cpf_pkg::ms_ticks(cpf_pkg::REL_DELAY_MS)
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       cell_above_ovp,
    input  wire logic       cell_above_ovp_rel,
    input  wire logic       cell_below_uvp,
    input  wire logic       cell_above_uvp_rel,
    input  wire logic       cell_above_inhibit,
    input  wire logic       sense_ge_ocd,
    input  wire logic       sense_ge_scc,
    input  wire logic       sense_lt_occ,
    input  wire logic       sense_gt_occ_min,
    input  wire logic       sense_lt_m0v7,
    input  wire logic       sense_le_cell_m1v,
    input  wire logic       sense_cell_diff_gt_1v3,
    input  wire logic       charger_ge_zv_start,
    output logic            charge_gate_on_ff,
    output logic [1:0]      charge_gate_mode_ff,
    output logic            discharge_gate_on_ff,
    output logic            pullup_en_ff,
    output logic            sink_en_ff,
    output logic            powerdown_ff,
    output logic [6:0]      state_ff
);
    localparam int NIN = 13;

    // Local names for the package states; nothing is imported
    typedef cpf_pkg::cpf_state_t cpf_state_t;
    localparam cpf_state_t CPF_NORMAL = cpf_pkg::CPF_NORMAL;
    localparam cpf_state_t CPF_OVC    = cpf_pkg::CPF_OVC;
    localparam cpf_state_t CPF_UVD    = cpf_pkg::CPF_UVD;
    localparam cpf_state_t CPF_PDOWN  = cpf_pkg::CPF_PDOWN;
    localparam cpf_state_t CPF_OCD    = cpf_pkg::CPF_OCD;
    localparam cpf_state_t CPF_OCC    = cpf_pkg::CPF_OCC;
    localparam cpf_state_t CPF_ZVCHG  = cpf_pkg::CPF_ZVCHG;

    // Divider counter must hold the tick division
    if (cpf_pkg::TICK_DIV < 2 || cpf_pkg::TICK_DIV > (1 << cpf_pkg::TICK_DIV_W)) begin : g_bad_div
        $error("cpf_fsm tick divider does not fit");
    end

    // Synchronised comparator levels
    logic [NIN-1:0] raw;
    logic [NIN-1:0] syn;
    logic overcharge_fault, ovp_rel_hi, overdischarge_fault, uvp_rel_hi, inh_ok, discharge_overcurrent_fault, scc, charge_overcurrent_fault, occ_min;
    logic m0v7, cellm1, diff13, zvchg;

    assign raw = {cell_above_ovp, cell_above_ovp_rel, cell_below_uvp, cell_above_uvp_rel,
                  cell_above_inhibit, sense_ge_ocd, sense_ge_scc, sense_lt_occ,
                  sense_gt_occ_min, sense_lt_m0v7, sense_le_cell_m1v,
                  sense_cell_diff_gt_1v3, charger_ge_zv_start};

    // Every comparator passes two flops before any decision
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            cpf_sync u_sync (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .ce      (ce),
                .d       (raw[gi]),
                .q       (syn[gi])
            );
        end
    endgenerate

    assign {overcharge_fault, ovp_rel_hi, overdischarge_fault, uvp_rel_hi, inh_ok, discharge_overcurrent_fault, scc, charge_overcurrent_fault,
            occ_min, m0v7, cellm1, diff13, zvchg} = syn;

    // 10 kHz tick divider
    logic [cpf_pkg::TICK_DIV_W-1:0] div_ff;
    logic                           tick_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            if (div_ff == cpf_pkg::TICK_DIV_W'(cpf_pkg::TICK_DIV - 1)) begin
                div_ff  <= '0;
                tick_ff <= 1'b1;
            end else begin
                div_ff  <= div_ff + 1'b1;
                tick_ff <= 1'b0;
            end
        end
    end

    // Detection and recovery timers
    cpf_tmr_if t_ovc ();
    cpf_tmr_if t_uvd ();
    cpf_tmr_if t_ocd ();
    cpf_tmr_if t_scc ();
    cpf_tmr_if t_occ ();
    cpf_tmr_if t_rel ();

    cpf_state_t st;
    logic       rel_cond;
    logic       chg_present_ff;

    assign st = cpf_state_t'(state_ff);

    assign t_ovc.tick = tick_ff;
    assign t_uvd.tick = tick_ff;
    assign t_ocd.tick = tick_ff;
    assign t_scc.tick = tick_ff;
    assign t_occ.tick = tick_ff;
    assign t_rel.tick = tick_ff;

    // Detection timers only run in normal state
    assign t_ovc.run = (st == CPF_NORMAL) && overcharge_fault;
    assign t_uvd.run = (st == CPF_NORMAL) && overdischarge_fault;
    assign t_ocd.run = (st == CPF_NORMAL) && discharge_overcurrent_fault && !overcharge_fault;
    assign t_scc.run = (st == CPF_NORMAL) && scc && !overcharge_fault;
    // Charge overcurrent never armed below undervoltage
    assign t_occ.run = (st == CPF_NORMAL) && charge_overcurrent_fault && !overdischarge_fault;
    assign t_rel.run = rel_cond;

    cpf_delay #(.LIMIT(OVC_TICKS)) u_ovc (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .t       (t_ovc)
    );
    cpf_delay #(.LIMIT(UVD_TICKS)) u_uvd (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .t       (t_uvd)
    );
    cpf_delay #(.LIMIT(OCD_TICKS)) u_ocd (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .t       (t_ocd)
    );
    cpf_delay #(.LIMIT(cpf_pkg::SC_DELAY_TICKS)) u_scc (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .t       (t_scc)
    );
    cpf_delay #(.LIMIT(OCC_TICKS)) u_occ (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .t       (t_occ)
    );
    // Recovery shares one timer; only one fault state is live at a time
    cpf_delay #(.LIMIT(REL_TICKS)) u_rel (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .t       (t_rel)
    );

    // Charger seen during overcharge: sense pulled below the charge overcurrent minimum
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chg_present_ff <= 1'b0;
        end else if (ce) begin
            if (st != CPF_OVC)
                chg_present_ff <= 1'b0;
            else if (!occ_min)
                chg_present_ff <= 1'b1;
            else if (discharge_overcurrent_fault)
                chg_present_ff <= 1'b0;
        end
    end

    // Release conditions per fault state; a lapse restarts the recovery timer
    always_comb begin
        rel_cond = 1'b0;
        case (st)
            CPF_OVC: begin
                if (chg_present_ff)
                    rel_cond = 1'b0;
                else if (discharge_overcurrent_fault)
                    rel_cond = !overcharge_fault;
                else if (occ_min)
                    rel_cond = !ovp_rel_hi;
            end
            CPF_UVD, CPF_PDOWN: begin
                if (m0v7)
                    rel_cond = !overdischarge_fault;
                else if (diff13 || st == CPF_UVD)
                    rel_cond = uvp_rel_hi;
            end
            CPF_OCD: rel_cond = cellm1;
            CPF_OCC: rel_cond = !charge_overcurrent_fault;
            CPF_ZVCHG: rel_cond = uvp_rel_hi;
            default: rel_cond = 1'b0;
        endcase
    end

    // Protection state machine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CPF_NORMAL;
        end else if (ce) begin
            case (st)
                CPF_NORMAL: begin
                    // Short trips ahead of slower faults
                    if (t_scc.done || t_ocd.done)
                        state_ff <= CPF_OCD;
                    else if (t_ovc.done)
                        state_ff <= CPF_OVC;
                    else if (t_uvd.done)
                        state_ff <= CPF_UVD;
                    else if (t_occ.done)
                        state_ff <= CPF_OCC;
                end
                CPF_UVD: begin
                    if (zvchg && overdischarge_fault)
                        state_ff <= CPF_ZVCHG;
                    else if (t_rel.done)
                        state_ff <= CPF_NORMAL;
                    else if (!diff13)
                        state_ff <= CPF_PDOWN;
                end
                CPF_PDOWN: begin
                    if (t_rel.done)
                        state_ff <= CPF_NORMAL;
                    else if (diff13)
                        state_ff <= CPF_UVD;
                end
                CPF_OVC, CPF_OCD, CPF_OCC, CPF_ZVCHG: begin
                    if (t_rel.done)
                        state_ff <= CPF_NORMAL;
                end
                default: state_ff <= CPF_NORMAL;
            endcase
        end
    end

    // Gate drives and sense switches follow the state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            charge_gate_on_ff    <= 1'b0;
            charge_gate_mode_ff  <= cpf_pkg::GATE_OFF;
            discharge_gate_on_ff <= 1'b0;
            pullup_en_ff         <= 1'b0;
            sink_en_ff           <= 1'b0;
            powerdown_ff         <= 1'b0;
        end else if (ce) begin
            // Shorted cell below inhibit level keeps the charge gate off in CPF_UVD, CPF_PDOWN and CPF_ZVCHG
            charge_gate_on_ff    <= (st == CPF_NORMAL) || (st == CPF_OCD) ||
                                    ((st == CPF_UVD || st == CPF_PDOWN || st == CPF_ZVCHG) && inh_ok);
            discharge_gate_on_ff <= (st == CPF_NORMAL) || (st == CPF_OVC) ||
                                    (st == CPF_OCC);
            pullup_en_ff         <= (st == CPF_UVD) || (st == CPF_PDOWN);
            sink_en_ff           <= (st == CPF_OCD);
            powerdown_ff         <= (st == CPF_PDOWN);
            // Inhibit overrides zero-volt charging for a shorted cell
            if (!inh_ok && (st == CPF_UVD || st == CPF_PDOWN || st == CPF_ZVCHG))
                charge_gate_mode_ff <= cpf_pkg::GATE_PACKNEG;
            else if (st == CPF_ZVCHG)
                charge_gate_mode_ff <= cpf_pkg::GATE_CELL;
            else if (st == CPF_OVC || st == CPF_OCC)
                charge_gate_mode_ff <= cpf_pkg::GATE_OFF;
            else
                charge_gate_mode_ff <= cpf_pkg::GATE_ON;
        end
    end
endmodule // cpf_fsm

/* File: cpf_fsm_monitor.sv */
// Checker for the protection controller, watching only its top ports.
// Assumes ce is held high and that the testbench binds it to the top module.
module cpf_fsm_monitor #(
    parameter int unsigned OCD_TICKS = 2
) (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       cell_above_ovp,
    input wire logic       sense_ge_ocd,
    input wire logic       sense_ge_scc,
    input wire logic       charge_gate_on_ff,
    input wire logic [1:0] charge_gate_mode_ff,
    input wire logic       discharge_gate_on_ff,
    input wire logic       pullup_en_ff,
    input wire logic       sink_en_ff,
    input wire logic       powerdown_ff,
    input wire logic [6:0] state_ff
);
    localparam int MIN_RUN = ((OCD_TICKS < 3) ? OCD_TICKS - 1 : 2) * cpf_pkg::TICK_DIV;
    localparam int MAX_RUN = (OCD_TICKS + 1) * cpf_pkg::TICK_DIV + 8;
    logic [1:0] flt_ff;
    logic [1:0] ovp_ff;
    int         run_ff;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Mirror of the input synchroniser, so run length matches what the timer sees
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flt_ff <= 2'h0;
            ovp_ff <= 2'h0;
        end else begin
            flt_ff <= {flt_ff[0], sense_ge_ocd | sense_ge_scc};
            ovp_ff <= {ovp_ff[0], cell_above_ovp};
        end
    end

    // Uninterrupted discharge fault run, counted only in normal state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) run_ff <= 32'h0;
        else if (flt_ff[1] && !ovp_ff[1] && state_ff == 7'h01) run_ff <= run_ff + 1;
        else run_ff <= 32'h0;
    end

    // Outputs trail the state by one edge, so a state is judged once held twice
    sequence s_held(logic [6:0] st);
        (state_ff == st) [*2];
    endsequence

    property p_normal;
        s_held(7'h01) |-> charge_gate_on_ff && discharge_gate_on_ff && charge_gate_mode_ff == cpf_pkg::GATE_ON;
    endproperty
    a_normal: assert property (p_normal) else $error("normal gates not both on");
    property p_ovc;
        s_held(7'h02) |-> !charge_gate_on_ff;
    endproperty
    a_ovc: assert property (p_ovc) else $error("charge gate on in overcharge");
    property p_uvd;
        s_held(7'h04) |-> !discharge_gate_on_ff && pullup_en_ff && !sink_en_ff;
    endproperty
    a_uvd: assert property (p_uvd) else $error("overdischarge outputs wrong");
    property p_pdown;
        s_held(7'h08) |-> powerdown_ff && !discharge_gate_on_ff && !sink_en_ff;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down outputs wrong");
    property p_ocd;
        s_held(7'h10) |-> !discharge_gate_on_ff && sink_en_ff && !pullup_en_ff;
    endproperty
    a_ocd: assert property (p_ocd) else $error("discharge fault outputs wrong");
    property p_occ;
        s_held(7'h20) |-> !charge_gate_on_ff && !pullup_en_ff && !sink_en_ff;
    endproperty
    a_occ: assert property (p_occ) else $error("charge fault outputs wrong");
    property p_ovp_blocks;
        state_ff == 7'h01 && ovp_ff[1] |=> state_ff != 7'h10;
    endproperty
    a_ovp_blocks: assert property (p_ovp_blocks) else $error("discharge trip while overcharged");
    property p_no_occ_uvd;
        state_ff == 7'h04 |=> state_ff != 7'h20;
    endproperty
    a_no_occ_uvd: assert property (p_no_occ_uvd) else $error("charge fault from overdischarge");
    property p_run_min;
        $past(state_ff) == 7'h01 && state_ff == 7'h10 |-> run_ff >= MIN_RUN;
    endproperty
    a_run_min: assert property (p_run_min) else $error("discharge trip too early");
    property p_run_max;
        state_ff == 7'h01 |-> run_ff <= MAX_RUN;
    endproperty
    a_run_max: assert property (p_run_max) else $error("discharge trip too late");
endmodule // cpf_fsm_monitor

/* File: cpf_cell_model.sv */
// Far side: cell, charger and load as seen through the comparators.
// Assumes the bench sets voltages in millivolts; thresholds are plain defaults.
module cpf_cell_model #(
    parameter int OVERCHARGE_FAULT = 4275, OVP_REL = 4175, OVERDISCHARGE_FAULT = 2800, UVP_REL = 2900, INH = 1000,
    parameter int DISCHARGE_OVERCURRENT_FAULT = 100, SCC = 500, CHARGE_OVERCURRENT_FAULT = -70, OCC_MIN = -20, ZVS = 1700
) (
    input  var int    cell_mv,
    input  var int    ext_mv,
    input  wire logic ext_on,
    input  wire logic pullup_en_ff,
    output logic      cell_above_ovp,
    output logic      cell_above_ovp_rel,
    output logic      cell_below_uvp,
    output logic      cell_above_uvp_rel,
    output logic      cell_above_inhibit,
    output logic      sense_ge_ocd,
    output logic      sense_ge_scc,
    output logic      sense_lt_occ,
    output logic      sense_gt_occ_min,
    output logic      sense_lt_m0v7,
    output logic      sense_le_cell_m1v,
    output logic      sense_cell_diff_gt_1v3,
    output logic      charger_ge_zv_start
);
    int sense;

    // Undriven sense pin follows the pull-up, else it sits at ground; the sink is not modelled
    always_comb begin
        sense = ext_on ? ext_mv : (pullup_en_ff ? cell_mv : 0);
        cell_above_ovp = cell_mv > OVERCHARGE_FAULT;
        cell_above_ovp_rel = cell_mv >= OVP_REL;
        cell_below_uvp = cell_mv < OVERDISCHARGE_FAULT;
        cell_above_uvp_rel = cell_mv >= UVP_REL;
        cell_above_inhibit = cell_mv >= INH;
        sense_ge_ocd = sense >= DISCHARGE_OVERCURRENT_FAULT;
        sense_ge_scc = sense >= SCC;
        sense_lt_occ = sense < CHARGE_OVERCURRENT_FAULT;
        sense_gt_occ_min = sense > OCC_MIN;
        sense_lt_m0v7 = sense < -700;
        sense_le_cell_m1v = sense <= cell_mv - 1000;
        sense_cell_diff_gt_1v3 = (sense > cell_mv + 1300) || (sense < cell_mv - 1300);
        charger_ge_zv_start = ext_on && ext_mv < 0 && (cell_mv - ext_mv) >= ZVS;
    end
endmodule // cpf_cell_model

/* File: test_cell_protection_fault_fsm.sv */
// Testbench: walks each protection state in, checks its outputs (overcharge only its state), walks it out.
// Assumes the cell model and the checker are compiled ahead of this file.
module test_cell_protection_fault_fsm;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys, rst_n, ce, ext_on;
    int         cell_mv, ext_mv, n_mismatch, checked;
    logic       cell_above_ovp, cell_above_ovp_rel, cell_below_uvp, cell_above_uvp_rel, cell_above_inhibit;
    logic       sense_ge_ocd, sense_ge_scc, sense_lt_occ, sense_gt_occ_min, sense_lt_m0v7;
    logic       sense_le_cell_m1v, sense_cell_diff_gt_1v3, charger_ge_zv_start;
    logic       charge_gate_on_ff, discharge_gate_on_ff, pullup_en_ff, sink_en_ff, powerdown_ff;
    logic [1:0] charge_gate_mode_ff;
    logic [6:0] state_ff;

    cpf_cell_model u_cell (.cell_mv, .ext_mv, .ext_on, .pullup_en_ff, .cell_above_ovp, .cell_above_ovp_rel,
        .cell_below_uvp, .cell_above_uvp_rel, .cell_above_inhibit, .sense_ge_ocd, .sense_ge_scc, .sense_lt_occ,
        .sense_gt_occ_min, .sense_lt_m0v7, .sense_le_cell_m1v, .sense_cell_diff_gt_1v3, .charger_ge_zv_start);
    // One-tick delays keep the run short; discharge keeps two so the glitch test means something
    cpf_fsm #(.OVC_TICKS(1), .UVD_TICKS(1), .OCD_TICKS(2), .OCC_TICKS(1), .REL_TICKS(1)) uut (.clk_sys,
        .rst_n, .ce, .cell_above_ovp, .cell_above_ovp_rel, .cell_below_uvp, .cell_above_uvp_rel,
        .cell_above_inhibit, .sense_ge_ocd, .sense_ge_scc, .sense_lt_occ, .sense_gt_occ_min, .sense_lt_m0v7,
        .sense_le_cell_m1v, .sense_cell_diff_gt_1v3, .charger_ge_zv_start, .charge_gate_on_ff,
        .charge_gate_mode_ff, .discharge_gate_on_ff, .pullup_en_ff, .sink_en_ff, .powerdown_ff, .state_ff);

    always #10 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Bounded wait, long enough for a two-tick detect plus a one-tick recovery
    task automatic wait_state(input logic [6:0] st);
        int i;
        i = 0;
        while (state_ff !== st && i < 20000) begin
            cyc(1);
            i++;
        end
        chk(state_ff, st);
    endtask

    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic t_normal_and_glitch;
        cyc(4);
        chk({charge_gate_on_ff, discharge_gate_on_ff, charge_gate_mode_ff}, {2'h3, cpf_pkg::GATE_ON});
        // Frozen enable: a load that would trip in two ticks must leave no mark
        ce = 1'h0;
        ext_mv = 300;
        cyc(10500);
        chk(state_ff, 7'h01);
        ce = 1'h1;
        ext_mv = 0;
        // Each burst is shorter than a tick spacing, so only a restart-free timer trips
        repeat (3) begin
            ext_mv = 300;
            cyc(4500);
            ext_mv = 0;
            cyc(20);
        end
        chk(state_ff, 7'h01);
    endtask

    task automatic t_discharge_fault;
        ext_mv = 300;
        wait_state(7'h10);
        cyc(2);
        chk({discharge_gate_on_ff, sink_en_ff, pullup_en_ff}, 3'h2);
        // Load still attached pulls sense to the cell, so no release may start
        ext_mv = 3600;
        cyc(5500);
        chk(state_ff, 7'h10);
        ext_mv = 0;
        wait_state(7'h01);
    endtask

    task automatic t_charge_fault;
        ext_mv = -200;
        wait_state(7'h20);
        cyc(2);
        chk({charge_gate_on_ff, pullup_en_ff, sink_en_ff}, 3'h0);
        ext_mv = 0;
        wait_state(7'h01);
    endtask

    task automatic t_depleted_cell;
        ext_on = 1'h0;
        cell_mv = 2500;
        wait_state(7'h04);
        cyc(2);
        chk({discharge_gate_on_ff, pullup_en_ff, sink_en_ff}, 3'h2);
        wait_state(7'h08);
        cyc(2);
        chk(powerdown_ff, 1'h1);
        ext_on = 1'h1;
        ext_mv = -2000;
        wait_state(7'h40);
        cyc(2);
        chk(charge_gate_mode_ff, cpf_pkg::GATE_CELL);
        cell_mv = 500;
        cyc(8);
        chk({charge_gate_on_ff, charge_gate_mode_ff}, {1'h0, cpf_pkg::GATE_PACKNEG});
        cell_mv = 3000;
        wait_state(7'h01);
        ext_mv = 0;
    endtask

    task automatic t_overcharge;
        // Load present from the start: only the overvoltage blocks the discharge timer
        cell_mv = 4400;
        ext_mv = 300;
        wait_state(7'h02);
        cyc(5500);
        chk(state_ff, 7'h02);
        cell_mv = 4250;
        wait_state(7'h01);
    endtask

    initial begin
        clk_sys = 1'h0;
        rst_n = 1'h0;
        ce = 1'h1;
        ext_on = 1'h1;
        cell_mv = 3600;
        ext_mv = 0;
        n_mismatch = 0;
        checked = 0;
        cyc(2);
        rst_n = 1'h1;
        t_normal_and_glitch();
        t_discharge_fault();
        t_charge_fault();
        t_depleted_cell();
        t_overcharge();
        tally_and_finish();
    end

    // Watchdog well past the roughly 80k cycles the sequence needs
    initial begin
        repeat (95000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // test_cell_protection_fault_fsm

bind cpf_fsm cpf_fsm_monitor #(.OCD_TICKS(OCD_TICKS)) u_mon (.clk_sys, .rst_n, .cell_above_ovp, .sense_ge_ocd,
    .sense_ge_scc, .charge_gate_on_ff, .charge_gate_mode_ff, .discharge_gate_on_ff, .pullup_en_ff, .sink_en_ff,
    .powerdown_ff, .state_ff);
